/* File: dv/cmb_engine_model.sv */
`timescale 1ns/10ps
`default_nettype none
module cmb_engine_model (
    // clock
    input wire logic clk,
    // engine strobes
    output logic bit_tick,
    output logic arb_req,
    output logic tx_eof_ok,
    output logic rx_wr,
    output logic [3:0] rx_wsel,
    output logic [7:0] rx_wdata,
    output logic rx_eof_ok
);
    logic [1:0] div = 2'h0;
    initial begin
        {arb_req, tx_eof_ok, rx_wr, rx_eof_ok} = 4'h0;
        rx_wsel = 4'h0;
        rx_wdata = 8'h00;
    end
    // bit clock runs free, one tick in four cycles
    always @(posedge clk) begin
        div <= div + 2'h1;
        bit_tick <= (div == 2'h3);
    end
    task arb();
        @(posedge clk) arb_req <= 1'b1;
        @(posedge clk) arb_req <= 1'b0;
    endtask
    task eof();
        @(posedge clk) tx_eof_ok <= 1'b1;
        @(posedge clk) tx_eof_ok <= 1'b0;
    endtask
    task rxb(input logic [3:0] s, input logic [7:0] d);
        @(posedge clk);
        rx_wr <= 1'b1;
        rx_wsel <= s;
        rx_wdata <= d;
        @(posedge clk);
        rx_wr <= 1'b0;
        // released data line must not look valid
        rx_wdata <= ~d;
        @(posedge clk) rx_eof_ok <= 1'b1;
        @(posedge clk) rx_eof_ok <= 1'b0;
    endtask
endmodule
`default_nettype wire

/* File: dv/cmb_store_bench.sv */
`timescale 1ns/10ps
`default_nettype none
module cmb_store_bench;
    logic clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, init_b = 1'b1;
    logic [7:0] addr = 8'h00, wdata = 8'h00, d;
    logic [2:0] tx_byte_sel = 3'h0, pend;
    wire bit_tick, arb_req, tx_eof_ok, rx_wr, rx_eof_ok, tx_valid, tx_remote, rx_full_flag;
    wire [3:0] rx_wsel, tx_length_code, tx_byte_count;
    wire [7:0] rx_wdata, rdata, tx_byte_data;
    wire [1:0] tx_index;
    wire [2:0] tx_empty_flag;
    logic [15:0] cnt = 16'h0, ste, str, st [0:2];
    logic [7:0] p [0:2], b [0:2][0:7];
    logic [3:0] l [0:2];
    logic [31:0] seed = 59;
    integer fails = 0, total_checks = 0, t, i, k, n, w;
    always #12.5 clk = ~clk;
    cmb_store u_dut (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .bit_tick(bit_tick), .arb_req(arb_req), .tx_eof_ok(tx_eof_ok),
        .tx_byte_sel(tx_byte_sel), .tx_valid(tx_valid), .tx_index(tx_index),
        .tx_length_code(tx_length_code), .tx_byte_count(tx_byte_count), .tx_remote(tx_remote),
        .tx_byte_data(tx_byte_data), .rx_wr(rx_wr), .rx_wsel(rx_wsel), .rx_wdata(rx_wdata),
        .rx_eof_ok(rx_eof_ok), .tx_empty_flag(tx_empty_flag), .rx_full_flag(rx_full_flag));
    cmb_engine_model u_eng (.clk(clk), .bit_tick(bit_tick), .arb_req(arb_req),
        .tx_eof_ok(tx_eof_ok), .rx_wr(rx_wr), .rx_wsel(rx_wsel), .rx_wdata(rx_wdata),
        .rx_eof_ok(rx_eof_ok));
    // mirror of the stamp counter, cleared to zero while in init mode
    always @(posedge clk) begin
        cnt <= (rst || init_b) ? 16'h0 : cnt + {15'h0, bit_tick};
        if (rst) init_b <= 1'b1;
        else if (wr && addr == 8'h20) init_b <= wdata[0];
        if (tx_eof_ok) ste <= cnt;
        if (rx_eof_ok) str <= cnt;
    end
    function automatic [31:0] xs(input [31:0] x);
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    function automatic [1:0] win(input [2:0] m);
        logic [1:0] r;
        r = 2'h3;
        for (int j = 2; j >= 0; j--) begin
            if (m[j] && (r == 2'h3 || p[j] <= p[r])) r = j[1:0];
        end
        return r;
    endfunction
    task chk(input string s, input logic [15:0] g, input logic [15:0] e);
        total_checks++;
        if (g !== e) begin
            fails++;
            $display("MISMATCH %s exp %h seen %h", s, e, g);
        end
    endtask
    task wrr(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk);
        addr <= a;
        wdata <= v;
        wr <= 1'b1;
        @(posedge clk) wr <= 1'b0;
    endtask
    task rdr(input logic [7:0] a);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk) rd <= 1'b0;
        #1 d = rdata;
    endtask
    task report_and_stop();
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        #500000;
        fails++;
        report_and_stop();
    end
    initial begin
        for (i = 0; i < 3; i++) st[i] = 16'h0;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        rdr(8'h21); chk("empty_rst", d, 8'h07);
        rdr(8'h20); chk("ctrl_rst", d, 8'h01);
        wrr(8'h20, 8'h02);
        for (t = 0; t < 4; t++) begin
            wrr(8'h24, t == 3 ? 8'h05 : 8'h00);
            for (i = 0; i < 3; i++) begin
                seed = xs(seed);
                p[i] = t == 1 ? 8'h40 : seed[7:0];
                l[i] = t == 2 ? 4'h8 + i[3:0] * 4'h7 : seed[11:8];
                wrr(8'h22, 8'h01 << i);
                wrr(8'h0d, p[i]);
                wrr(8'h0c, {4'h0, l[i]});
                for (k = 0; k < 8; k++) begin
                    seed = xs(seed);
                    b[i][k] = seed[7:0];
                    wrr(8'h04 + k[7:0], b[i][k]);
                end
                rdr(8'h0d); chk("local_priority", d, p[i]);
                rdr(8'h0c); chk("len", d[3:0], l[i]);
                wrr(8'h0e, 8'hff);
                rdr(8'h0e); chk("stamp_ro", d, st[i][15:8]);
            end
            wrr(8'h21, 8'h07);
            pend = 3'h7;
            for (n = 0; n < 3; n++) begin
                u_eng.arb();
                #1 w = win(pend);
                chk("index", tx_index, w);
                chk("len_out", tx_length_code, l[w]);
                chk("count", tx_byte_count, t == 3 && w != 1 ? 4'h0 : (l[w] > 8 ? 4'h8 : l[w]));
                chk("remote", tx_remote, t == 3 && w != 1);
                seed = xs(seed);
                @(posedge clk) tx_byte_sel <= seed[2:0];
                @(posedge clk) #1 chk("byte", tx_byte_data, b[w][seed[2:0]]);
                u_eng.eof();
                #1 st[w] = ste;
                chk("freed", tx_empty_flag[w], 1'b1);
                pend[w] = 1'b0;
            end
            u_eng.arb();
            #1 chk("none", tx_valid, 1'b0);
            for (i = 0; i < 3; i++) begin
                wrr(8'h22, 8'h01 << i);
                rdr(8'h0e); chk("stamp_hi", d, st[i][15:8]);
                rdr(8'h0f); chk("stamp_lo", d, st[i][7:0]);
            end
            $display("test queue %0d done", t);
        end
        u_eng.rxb(4'h4, 8'h5a);
        #1 chk("rx_full", rx_full_flag, 1'b1);
        rdr(8'h14); chk("rx_byte", d, 8'h5a);
        rdr(8'h1e); chk("rx_stamp_hi", d, str[15:8]);
        rdr(8'h1f); chk("rx_stamp_lo", d, str[7:0]);
        rdr(8'h30); chk("unmapped", d, 8'h00);
        wrr(8'h23, 8'h01);
        #1 chk("rx_clear", rx_full_flag, 1'b0);
        // init mode clears the counter to zero, so a stamp taken there is zero
        wrr(8'h20, 8'h03);
        seed = xs(seed);
        u_eng.rxb(4'h7, seed[7:0]);
        rdr(8'h17); chk("rx_byte_init", d, seed[7:0]);
        rdr(8'h1e); chk("rx_stamp_init_hi", d, 8'h00);
        rdr(8'h1f); chk("rx_stamp_init_lo", d, 8'h00);
        $display("test receive done");
        report_and_stop();
    end
endmodule
`default_nettype wire

/* File: dv/cmb_store_props.sv */
`timescale 1ns/10ps
`default_nettype none
module cmb_store_props (
    // clock and reset
    input wire clk,
    input wire rst,
    // observed
    input wire rd,
    input wire [7:0] rdata,
    input wire arb_req,
    input wire tx_eof_ok,
    input wire tx_valid,
    input wire [1:0] tx_index,
    input wire [3:0] tx_length_code,
    input wire [3:0] tx_byte_count,
    input wire tx_remote,
    input wire [2:0] tx_empty_flag,
    input wire rx_eof_ok,
    input wire rx_full_flag
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    sequence s_done;
        tx_valid && tx_eof_ok;
    endsequence
    sequence s_none;
        arb_req && tx_empty_flag == 3'h7;
    endsequence
    AST_RD_IDLE: assert property (!$past(rd) |-> rdata == 8'h00)
        else $error("read data outside read slot");
    AST_REMOTE: assert property (tx_valid && tx_remote |-> tx_byte_count == 4'h0)
        else $error("remote frame with payload");
    AST_COUNT: assert property (tx_valid && !tx_remote |->
        tx_byte_count == (tx_length_code > 4'h8 ? 4'h8 : tx_length_code))
        else $error("byte count not from length code");
    AST_FREE: assert property (s_done |=> tx_empty_flag[$past(tx_index)] && !tx_valid)
        else $error("buffer not released after send");
    AST_PEND: assert property (tx_valid |-> !tx_empty_flag[tx_index])
        else $error("chosen buffer is empty");
    AST_RANGE: assert property (tx_valid |-> tx_index < 2'h3)
        else $error("buffer index out of range");
    AST_NONE: assert property (s_none |=> !tx_valid)
        else $error("choice with no pending buffer");
    AST_RXF: assert property (rx_eof_ok && !rx_full_flag |=> rx_full_flag)
        else $error("receive full not set");
endmodule
bind cmb_store cmb_store_props u_props (.clk(clk), .rst(rst), .rd(rd), .rdata(rdata),
    .arb_req(arb_req), .tx_eof_ok(tx_eof_ok), .tx_valid(tx_valid), .tx_index(tx_index),
    .tx_length_code(tx_length_code), .tx_byte_count(tx_byte_count), .tx_remote(tx_remote),
    .tx_empty_flag(tx_empty_flag), .rx_eof_ok(rx_eof_ok), .rx_full_flag(rx_full_flag));
`default_nettype wire

/* File: hdl/cmb_consts.vh */
`ifndef CMB_CONSTS_VH
`define CMB_CONSTS_VH

// offsets inside a buffer window
`define CMB_OFS_PAY0 4'h4
`define CMB_OFS_PAY7 4'hb
`define CMB_OFS_LEN 4'hc
`define CMB_OFS_LOCAL_PRIORITY 4'hd
`define CMB_OFS_STH 4'he
`define CMB_OFS_STL 4'hf

// register map
`define CMB_ADR_RX_BASE 8'h10
`define CMB_ADR_CTRL 8'h20
`define CMB_ADR_TXFLG 8'h21
`define CMB_ADR_TBSEL 8'h22
`define CMB_ADR_RXFLG 8'h23
`define CMB_ADR_RTR 8'h24

// control fields
`define CMB_CTRL_INIT 0
`define CMB_CTRL_TIME 1

// reset values
`define CMB_RST_CTRL 2'h1
`define CMB_RST_TXE 3'h7
`define CMB_RST_SEL 3'h0

`define CMB_MAX_BYTES 4'h8
`define CMB_NUM_TX 3

`endif

/* File: hdl/cmb_local_priority_select.v */
`timescale 1ns/10ps
`default_nettype none
`include "cmb_consts.vh"
module cmb_local_priority_select (
    // candidates
    input wire [2:0] pending,
    input wire [7:0] local_priority_0,
    input wire [7:0] local_priority_1,
    input wire [7:0] local_priority_2,
    // winner
    output reg win_valid,
    output reg [1:0] win_index
);
    reg [7:0] best;

    // strict less-than keeps the lower index on a tie
    always @* begin
        win_valid = 1'b0;
        win_index = 2'h0;
        best = 8'hff;
        if (pending[0]) begin
            win_valid = 1'b1;
            win_index = 2'h0;
            best = local_priority_0;
        end
        if (pending[1] && (!win_valid || local_priority_1 < best)) begin
            win_valid = 1'b1;
            win_index = 2'h1;
            best = local_priority_1;
        end
        if (pending[2] && (!win_valid || local_priority_2 < best)) begin
            win_valid = 1'b1;
            win_index = 2'h2;
            best = local_priority_2;
        end
    end
endmodule
`default_nettype wire

/* File: hdl/cmb_stamp_counter.v */
`timescale 1ns/10ps
`default_nettype none
`include "cmb_consts.vh"
module cmb_stamp_counter (
    // clock and reset
    input wire clk,
    input wire rst,
    // control
    input wire init_mode,
    input wire bit_tick,
    // count
    output reg [15:0] count
);
    // wrap to zero silently, nobody is told
    always @(posedge clk) begin
        if (rst) begin
            count <= 16'h0000;
        end else if (init_mode) begin
            count <= 16'h0000;
        end else if (bit_tick) begin
            count <= count + 16'h0001;
        end
    end
endmodule
`default_nettype wire

/* File: hdl/cmb_store.v */
// The address-and-strobe port is this design's own decision.
`timescale 1ns/10ps
`default_nettype none
`include "cmb_consts.vh"
module cmb_store (
    // clock and reset
    input wire clk,
    input wire rst,
    // register port
    input wire [7:0] addr,
    input wire [7:0] wdata,
    input wire wr,
    input wire rd,
    output reg [7:0] rdata,
    // bit clock enable from the protocol engine
    input wire bit_tick,
    // transmit side of the protocol engine
    input wire arb_req,
    input wire tx_eof_ok,
    input wire [2:0] tx_byte_sel,
    output reg tx_valid,
    output reg [1:0] tx_index,
    output reg [3:0] tx_length_code,
    output reg [3:0] tx_byte_count,
    output reg tx_remote,
    output reg [7:0] tx_byte_data,
    // receive side of the protocol engine
    input wire rx_wr,
    input wire [3:0] rx_wsel,
    input wire [7:0] rx_wdata,
    input wire rx_eof_ok,
    // status
    output reg [2:0] tx_empty_flag,
    output reg rx_full_flag
);
    // three transmit windows of sixteen bytes and one receive window
    reg [7:0] tx_mem [0:47];
    reg [7:0] rx_mem [0:15];
    // stamps live apart from the byte arrays so a bus write can never reach them
    reg [15:0] tx_stamp [0:2];
    reg [15:0] rx_stamp;

    // control and flag registers
    reg [1:0] control_reg_zero;
    reg [2:0] tx_buffer_select;
    reg [2:0] remote_bits;

    wire init_mode;
    wire stamp_en;
    wire [15:0] stamp_now;
    wire [2:0] next_tx_empty;
    wire next_rx_full;

    // selector
    wire win_valid;
    wire [1:0] win_index;
    wire [7:0] local_priority [0:2];

    // bus decode
    wire in_tx_win;
    wire in_rx_win;
    wire sel_ok;
    wire [1:0] sel_idx;
    wire [3:0] ofs;
    wire [7:0] rx_base;

    // write decodes, one per control register
    wire wr_ctrl;
    wire wr_txflg;
    wire wr_tbsel;
    wire wr_rxflg;
    wire wr_rtr;
    wire tx_wr_ok;
    wire rx_wr_ok;
    wire tx_done;
    wire rx_done;

    // read data before the output register
    reg [7:0] next_rdata;

    assign init_mode = control_reg_zero[`CMB_CTRL_INIT];
    assign stamp_en = control_reg_zero[`CMB_CTRL_TIME];
    assign ofs = addr[3:0];
    assign in_tx_win = (addr[7:4] == 4'h0);
    assign rx_base = `CMB_ADR_RX_BASE;
    assign in_rx_win = (addr[7:4] == rx_base[7:4]);

    function [5:0] mem_index;
        input [1:0] buf_idx;
        input [3:0] offset;
        begin
            mem_index = {buf_idx, offset};
        end
    endfunction

    // lowest set bit of a three-bit mask
    function [1:0] low_index;
        input [2:0] mask;
        begin
            if (mask[0]) begin
                low_index = 2'h0;
            end else if (mask[1]) begin
                low_index = 2'h1;
            end else begin
                low_index = 2'h2;
            end
        end
    endfunction

    // count of bytes actually sent for a given length code
    function [3:0] byte_count;
        input [3:0] code;
        input remote;
        begin
            if (remote) begin
                byte_count = 4'h0;
            end else if (code > `CMB_MAX_BYTES) begin
                byte_count = `CMB_MAX_BYTES;
            end else begin
                byte_count = code;
            end
        end
    endfunction

    // exact match of a control register address
    function reg_hit;
        input [7:0] a;
        input [7:0] target;
        begin
            reg_hit = (a == target);
        end
    endfunction

    assign wr_ctrl = wr && reg_hit(addr, `CMB_ADR_CTRL);
    assign wr_txflg = wr && reg_hit(addr, `CMB_ADR_TXFLG);
    assign wr_tbsel = wr && reg_hit(addr, `CMB_ADR_TBSEL);
    assign wr_rxflg = wr && reg_hit(addr, `CMB_ADR_RXFLG);
    assign wr_rtr = wr && reg_hit(addr, `CMB_ADR_RTR);
    // stamp bytes sit above the writable part of a window
    assign tx_wr_ok = wr && in_tx_win && sel_ok && ofs < `CMB_OFS_STH;
    assign rx_wr_ok = rx_wr && !rx_full_flag && rx_wsel < `CMB_OFS_STH;
    assign tx_done = tx_eof_ok && tx_valid;
    // a message arriving while the foreground is full is dropped with its stamp
    assign rx_done = rx_eof_ok && !rx_full_flag;

    // the selected buffer is reachable only while it is empty
    assign sel_ok = |(tx_buffer_select & tx_empty_flag);
    assign sel_idx = low_index(tx_buffer_select);

    genvar gi;
    generate
        for (gi = 0; gi < `CMB_NUM_TX; gi = gi + 1) begin : g_local_priority
            localparam [1:0] buf_num = gi;
            assign local_priority[gi] = tx_mem[mem_index(buf_num, `CMB_OFS_LOCAL_PRIORITY)];
        end
    endgenerate

    cmb_local_priority_select u_sel (
        .pending(~tx_empty_flag),
        .local_priority_0(local_priority[0]),
        .local_priority_1(local_priority[1]),
        .local_priority_2(local_priority[2]),
        .win_valid(win_valid),
        .win_index(win_index)
    );

    cmb_stamp_counter u_cnt (
        .clk(clk),
        .rst(rst),
        .init_mode(init_mode),
        .bit_tick(bit_tick),
        .count(stamp_now)
    );

    // control registers
    always @(posedge clk) begin
        if (rst) begin
            control_reg_zero <= `CMB_RST_CTRL;
            tx_buffer_select <= `CMB_RST_SEL;
            remote_bits <= 3'h0;
        end else if (wr) begin
            if (wr_ctrl) begin
                control_reg_zero <= wdata[1:0];
            end
            if (wr_rtr) begin
                remote_bits <= wdata[2:0];
            end
            if (wr_tbsel) begin
                // keep only the lowest empty buffer asked for
                if (|(wdata[2:0] & tx_empty_flag)) begin
                    tx_buffer_select <= 3'h1 << low_index(wdata[2:0] & tx_empty_flag);
                end else begin
                    tx_buffer_select <= 3'h0;
                end
            end
        end
    end

    // transmit buffer contents; stamp bytes are not in this array
    always @(posedge clk) begin
        if (tx_wr_ok) begin
            tx_mem[mem_index(sel_idx, ofs)] <= wdata;
        end
    end

    // receive buffer contents, filled by the engine while foreground is free
    always @(posedge clk) begin
        if (rx_wr_ok) begin
            rx_mem[rx_wsel] <= rx_wdata;
        end
    end

    // empty flags: software clears to queue, hardware sets after the send
    // the set wins over a clear in the same cycle so a finished send is not lost
    genvar fi;
    generate
        for (fi = 0; fi < `CMB_NUM_TX; fi = fi + 1) begin : g_flag
            localparam [1:0] flag_num = fi;
            wire clr_req;
            wire set_req;
            assign clr_req = wr_txflg && wdata[fi];
            assign set_req = tx_done && (tx_index == flag_num);
            assign next_tx_empty[fi] = set_req | (tx_empty_flag[fi] & ~clr_req);
        end
    endgenerate

    assign next_rx_full = (rx_full_flag & ~(wr_rxflg && wdata[0])) | rx_eof_ok;

    always @(posedge clk) begin
        if (rst) begin
            tx_empty_flag <= `CMB_RST_TXE;
            rx_full_flag <= 1'b0;
        end else begin
            tx_empty_flag <= next_tx_empty;
            rx_full_flag <= next_rx_full;
        end
    end

    // time stamps taken right after a valid end of frame
    always @(posedge clk) begin
        if (rst) begin
            tx_stamp[0] <= 16'h0000;
            tx_stamp[1] <= 16'h0000;
            tx_stamp[2] <= 16'h0000;
            rx_stamp <= 16'h0000;
        end else begin
            if (stamp_en && tx_done) begin
                tx_stamp[tx_index] <= stamp_now;
            end
            if (stamp_en && rx_done) begin
                rx_stamp <= stamp_now;
            end
        end
    end

    // arbitration: selection redone on every attempt, nothing in init mode
    always @(posedge clk) begin
        if (rst) begin
            tx_valid <= 1'b0;
            tx_index <= 2'h0;
            tx_length_code <= 4'h0;
            tx_byte_count <= 4'h0;
            tx_remote <= 1'b0;
        end else if (init_mode) begin
            tx_valid <= 1'b0;
        end else if (arb_req) begin
            tx_valid <= win_valid;
            tx_index <= win_index;
            tx_length_code <= tx_mem[mem_index(win_index, `CMB_OFS_LEN)][3:0];
            tx_remote <= remote_bits[win_index];
            tx_byte_count <= byte_count(tx_mem[mem_index(win_index, `CMB_OFS_LEN)][3:0],
                remote_bits[win_index]);
        end else if (tx_eof_ok) begin
            tx_valid <= 1'b0;
        end
    end

    // payload byte for the engine, one cycle after it names the byte
    // no check against the count: the engine never asks for bytes past it
    always @(posedge clk) begin
        if (rst) begin
            tx_byte_data <= 8'h00;
        end else begin
            tx_byte_data <= tx_mem[mem_index(tx_index, `CMB_OFS_PAY0 + {1'b0, tx_byte_sel})];
        end
    end

    // read port: data worked out beside the strobe, registered so it stands one cycle only
    always @* begin
        next_rdata = 8'h00;
        if (!rd) begin
            next_rdata = 8'h00;
        end else if (in_tx_win) begin
            // a buffer that is queued or not selected reads as zero, not stale bytes
            if (!sel_ok) begin
                next_rdata = 8'h00;
            end else if (ofs == `CMB_OFS_STH) begin
                next_rdata = tx_stamp[sel_idx][15:8];
            end else if (ofs == `CMB_OFS_STL) begin
                next_rdata = tx_stamp[sel_idx][7:0];
            end else if (ofs == `CMB_OFS_LEN) begin
                next_rdata = {4'h0, tx_mem[mem_index(sel_idx, ofs)][3:0]};
            end else begin
                next_rdata = tx_mem[mem_index(sel_idx, ofs)];
            end
        end else if (in_rx_win) begin
            if (ofs == `CMB_OFS_STH) begin
                next_rdata = rx_stamp[15:8];
            end else if (ofs == `CMB_OFS_STL) begin
                next_rdata = rx_stamp[7:0];
            end else begin
                next_rdata = rx_mem[ofs];
            end
        end else begin
            case (addr)
                `CMB_ADR_CTRL: begin
                    next_rdata = {6'h00, control_reg_zero};
                end
                `CMB_ADR_TXFLG: begin
                    next_rdata = {5'h00, tx_empty_flag};
                end
                `CMB_ADR_TBSEL: begin
                    next_rdata = {5'h00, tx_buffer_select};
                end
                `CMB_ADR_RXFLG: begin
                    next_rdata = {7'h00, rx_full_flag};
                end
                `CMB_ADR_RTR: begin
                    next_rdata = {5'h00, remote_bits};
                end
                default: begin
                    next_rdata = 8'h00;
                end
            endcase
        end
    end

    always @(posedge clk) begin
        if (rst) begin
            rdata <= 8'h00;
        end else begin
            rdata <= next_rdata;
        end
    end
endmodule
`default_nettype wire
